/* File: verif/an_link_partner.sv */
// remote link partner model: one base page per burst window, then its link comes up
// assumes the device drives flp_send and tx_halt synchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none

module an_link_partner (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        flp_send_i,
  input  wire logic        tx_halt_i,
  input  wire logic        negotiates_i,
  input  wire logic        want_10_i,
  input  wire logic        want_100_i,
  input  wire logic [7:0]  dly_i,
  input  wire logic [15:0] word_i,
  output logic             page_valid_o,
  output logic      [15:0] page_word_o,
  output logic             link_ok_10_o,
  output logic             link_ok_100_o
);
  logic [7:0] cnt  = 8'h00;
  logic       sent = 1'b0;
  logic       pv   = 1'b0;

  always @(posedge clk_sys_i)
  begin
    pv <= 1'b0;
    if (rst_i || tx_halt_i || !flp_send_i)
      cnt <= 8'h00;
    else if (cnt != 8'hFF)
      cnt <= cnt + 8'h01;
    // partner falls into link fail during the break
    if (rst_i || tx_halt_i)
      sent <= 1'b0;
    else if (negotiates_i && flp_send_i && !sent && cnt == dly_i)
    begin
      pv   <= 1'b1;
      sent <= 1'b1;
    end
  end

  // code word lines carry junk outside the one valid cycle
  assign page_valid_o  = pv;
  assign page_word_o   = pv ? word_i : ~word_i;
  assign link_ok_10_o  = want_10_i && !tx_halt_i && (!negotiates_i || sent);
  assign link_ok_100_o = want_100_i && !tx_halt_i && (!negotiates_i || sent);
endmodule // an_link_partner

`default_nettype wire

/* File: verif/test_an_autoneg_ctrl.sv */
// self-checking bench of the negotiation control block
// assumes the partner model in an_link_partner.sv
`timescale 1ns/1ps
`default_nettype none

module test_an_autoneg_ctrl;
  import an_pkg::*;
  localparam int BRK = 20;
  localparam int ISO = 30;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, strap = 1'b1, az_strap = 1'b0;
  logic [4:0] addr = 5'h00;
  logic wr = 1'b0, rd_s = 1'b0, pv, l10, l100, flp, halt, up, s100, fd, iso;
  logic [15:0] wdata = 16'h0000, rdata, pw, fword, rv, pword = 16'h21E1;
  logic neg = 1'b1, w10 = 1'b1, w100 = 1'b1;
  logic [7:0] dly = 8'h01;
  int error_cnt = 0, check_count = 0, wk, i;
  logic [15:0] adv [4] = '{16'h01E1, 16'h00E1, 16'h0061, 16'h0021};
  logic [1:0]  exp [4] = '{2'b11, 2'b10, 2'b01, 2'b00};

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
`define WAITC(c, n) for (wk = 0; wk < (n) && !(c); wk++) begin @(posedge clk_sys_i); #1; end

  initial
  begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  an_autoneg_ctrl #(.BREAK_CYCLES(BRK), .ISO_RST_CYCLES(ISO)) uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .advertise_strap_i(strap),
    .addr_zero_strap_i(az_strap), .mgmt_addr_i(addr), .mgmt_wr_i(wr),
    .mgmt_wdata_i(wdata), .mgmt_rd_i(rd_s), .mgmt_rdata_o(rdata),
    .page_valid_i(pv), .page_word_i(pw), .link_ok_10_i(l10), .link_ok_100_i(l100),
    .flp_send_o(flp), .flp_word_o(fword), .tx_halt_o(halt), .link_up_o(up),
    .speed_100_o(s100), .full_duplex_o(fd), .isolate_o(iso));

  an_link_partner lp (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .flp_send_i(flp), .tx_halt_i(halt),
    .negotiates_i(neg), .want_10_i(w10), .want_100_i(w100), .dly_i(dly),
    .word_i(pword), .page_valid_o(pv), .page_word_o(pw), .link_ok_10_o(l10),
    .link_ok_100_o(l100));

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    @(posedge clk_sys_i);
    #1 rv = rdata;
  endtask

  // restart, then measure the break and wait for a link in the new mode
  task automatic renegotiate(input logic [15:0] ctl);
    wr_reg(OFS_BASIC_CTRL, ctl);
    #1;
    `WAITC(halt, 3)
    `CHK({halt, flp}, 2'b10)
    `WAITC(!halt, BRK + 5)
    `CHK(wk inside {BRK - 1, BRK, BRK + 1}, 1'b1)
    `CHK({halt, flp}, 2'b01)
    `WAITC(up, 200)
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_sys_i);
    error_cnt++;
    close_out();
  end

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    `WAITC(!iso, ISO + 3)
    `CHK(iso, 1'b0)
    `CHK(fword, ADV_RST_ALL)
    rd_reg(OFS_ADVERT);
    `CHK(rv, ADV_RST_ALL)
    `WAITC(up, 200)
    `CHK({up, s100, fd}, 3'b111)
    rd_reg(OFS_BASIC_STAT);
    `CHK(rv, STAT_FIXED | 16'h0034)
    rd_reg(OFS_PARTNER);
    `CHK(rv, 16'h21E1)
    rd_reg(OFS_PHY_STATUS);
    `CHK(rv, 16'h0005)
    rd_reg(OFS_EXPANSION);
    `CHK(rv, 16'h0007)
    pword = 16'h01E1;
    for (i = 0; i < 4; i++)
    begin
      dly <= (i[0]) ? 8'h28 : 8'h00;
      wr_reg(OFS_ADVERT, adv[i]);
      renegotiate(16'h1200);
      `CHK({up, s100, fd}, {1'b1, exp[i]})
      `CHK(fword, adv[i])
    end
    w10 <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    `WAITC(halt, 3)
    `CHK(halt, 1'b1)
    w10 <= 1'b1;
    `WAITC(up, BRK + 200)
    `CHK({up, s100, fd}, 3'b100)
    wr_reg(OFS_BASIC_CTRL, 16'h2100);
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK({s100, fd}, 2'b11)
    wr_reg(OFS_BASIC_CTRL, 16'h0000);
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK({s100, fd}, 2'b00)
    neg  <= 1'b0;
    w100 <= 1'b0;
    renegotiate(16'h1000);
    `CHK({up, s100, fd}, 3'b100)
    rd_reg(OFS_PARTNER);
    `CHK(rv, PD_WORD_10)
    rd_reg(OFS_EXPANSION);
    `CHK(rv, 16'h0006)
    wr_reg(OFS_BASIC_CTRL, 16'h3100);
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK({up, s100, fd}, 3'b100)
    w10  <= 1'b0;
    w100 <= 1'b1;
    renegotiate(16'h1200);
    `CHK({up, s100, fd}, 3'b110)
    rd_reg(OFS_PARTNER);
    `CHK(rv, PD_WORD_100)
    w10 <= 1'b1;
    wr_reg(OFS_BASIC_CTRL, 16'h1200);
    repeat (BRK + 20) @(posedge clk_sys_i);
    rd_reg(OFS_EXPANSION);
    `CHK(rv, 16'h0014)
    wr_reg(OFS_BASIC_CTRL, 16'h1400);
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK(iso, 1'b1)
    wr_reg(OFS_BASIC_CTRL, 16'h1000);
    `WAITC(!iso, ISO_CLR_CYC + 3)
    `CHK(iso, 1'b0)
    rd_reg(5'h1F);
    `CHK(rv, 16'h0000)
    wr_reg(OFS_ADVERT, 16'h0021);
    wr_reg(OFS_BASIC_CTRL, 16'h8000);
    repeat (2) @(posedge clk_sys_i);
    #1 `CHK(iso, 1'b1)
    `WAITC(!iso, ISO + 3)
    `CHK(iso, 1'b0)
    rd_reg(OFS_ADVERT);
    `CHK(rv, ADV_RST_ALL)
    @(posedge clk_sys_i);
    rst_i    <= 1'b1;
    strap    <= 1'b0;
    az_strap <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_reg(OFS_ADVERT);
    `CHK(rv, ADV_RST_HALF)
    rd_reg(OFS_BASIC_CTRL);
    `CHK(rv & 16'h0400, 16'h0400)
    repeat (ISO + 5) @(posedge clk_sys_i);
    #1 `CHK(iso, 1'b1)
    close_out();
  end
endmodule // test_an_autoneg_ctrl

`default_nettype wire

/* File: verilog/an_autoneg_ctrl.sv */
// negotiation control, status registers and isolate exit timing
// assumes management register strobes and receiver link levels synchronous to clk_sys_i
//
// Overview of operation
// - strap level is captured during reset to set advertised bits 8:5.
// - basic control register at offset zero is writable at any time.
// - while enabled, advertisement register contents are sent in link pulse bursts.
// - resolution prefers 100 full, 100 half, 10 full, then 10 half.
// - with negotiation off, speed and duplex bits set the operating mode.
// - with negotiation on, speed and duplex bits do not affect the mode.
// - phy status register at 0x10 reports resolved speed once link is up.
// - basic status ability bits are constant ones, only the T4 bit reads zero.
// - basic status shows completion, remote fault, link and preamble suppression.
// - advertisement defaults to all abilities with strap high, half duplex only with strap low; software may clear bits to withhold.
// - partner register captures base and next page code words received.
// - parallel detect loads partner register with 0081h for 100, 0021h for 10.
// - parallel detect sets partner selector field 4:0 to 00001.
// - expansion register shows detect fault, partner/local next page, page, partner able.
// - only one receiver may report link; the valid one picks the parallel detect technology.
// - partner negotiation able reads zero when completion came from parallel detect.
// - two good links at once during parallel detect set the fault flag; no link sets nothing.
// - writing the restart bit 9 with enable bit 12 set forces a fresh negotiation at any time.
// - losing link in the negotiated mode resumes negotiation automatically.
// - renegotiation halts transmit and pulses for the 1500 ms break timer.
// - clearing isolate bit 10 leaves isolate mode within 100 us.
// - after hardware or software reset, isolate mode ends within 500 us unless address zero is strapped.
// - isolate is entered by writing bit 10 or by a strapped address of zero.
`timescale 1ns/1ps
`default_nettype none

module an_autoneg_ctrl #(
  parameter int BREAK_CYCLES   = an_pkg::BREAK_CYC,
  parameter int ISO_RST_CYCLES = an_pkg::ISO_RST_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        advertise_strap_i,
  input  wire logic        addr_zero_strap_i,
  input  wire logic [4:0]  mgmt_addr_i,
  input  wire logic        mgmt_wr_i,
  input  wire logic [15:0] mgmt_wdata_i,
  input  wire logic        mgmt_rd_i,
  output logic      [15:0] mgmt_rdata_o,
  input  wire logic        page_valid_i,
  input  wire logic [15:0] page_word_i,
  input  wire logic        link_ok_10_i,
  input  wire logic        link_ok_100_i,
  output logic             flp_send_o,
  output logic      [15:0] flp_word_o,
  output logic             tx_halt_o,
  output logic             link_up_o,
  output logic             speed_100_o,
  output logic             full_duplex_o,
  output logic             isolate_o
);
  import an_pkg::*;

  localparam logic [25:0] BREAK_LAST = 26'(BREAK_CYCLES - 1);
  localparam logic [13:0] ISO_CLR_N  = 14'(ISO_CLR_CYC - 1);
  localparam logic [13:0] ISO_RST_N  = 14'(ISO_RST_CYCLES - 1);

  typedef struct packed {
    an_state_t   st;
    logic [15:0] advert;
    logic [15:0] partner;
    logic        strap_adv;
    logic        strap_iso;
    logic        an_en;
    logic        speed_sel;
    logic        duplex_sel;
    logic        isolate_bit;
    logic        an_complete;
    logic        lp_an_able;
    logic        lp_next_page;
    logic        page_rx;
    logic        pd_fault;
    logic        res_100;
    logic        res_fd;
    logic        link_up;
    logic        isolating;
    logic        iso_after_rst;
    logic [25:0] brk_cnt;
    logic [13:0] iso_cnt;
    logic [15:0] rdata;
  } an_regs_t;

  an_regs_t r;
  an_regs_t next_r;

  logic [15:0] basic_control_rd;
  logic [15:0] basic_status_reg_rd;
  logic [15:0] negotiation_expansion_reg_rd;
  logic [15:0] phy_link_status_rd;
  logic [3:0]  common;
  logic        res_link_ok;
  logic        one_link;
  logic        ctl_wr;

  always_comb
  begin
    basic_control_rd = 16'h0000;
    basic_control_rd[CTL_SPEED_100] = r.speed_sel;
    basic_control_rd[CTL_AN_ENABLE] = r.an_en;
    basic_control_rd[CTL_ISOLATE] = r.isolate_bit;
    basic_control_rd[CTL_FULL_DUPLEX] = r.duplex_sel;
    basic_status_reg_rd = STAT_FIXED;
    basic_status_reg_rd[5] = r.an_complete;
    basic_status_reg_rd[4] = r.partner[ADV_REMOTE_FLT] & r.lp_an_able;
    basic_status_reg_rd[2] = r.link_up;
    negotiation_expansion_reg_rd = {11'h000, r.pd_fault, r.lp_next_page, 1'b1, r.page_rx, r.lp_an_able};
    phy_link_status_rd = {13'h0000, r.res_fd, ~r.res_100, r.link_up};
    common = r.advert[ADV_100_FD:ADV_10_HD] & page_word_i[ADV_100_FD:ADV_10_HD];
    res_link_ok = r.res_100 ? link_ok_100_i : link_ok_10_i;
    one_link = link_ok_10_i ^ link_ok_100_i;
    ctl_wr = mgmt_wr_i && (mgmt_addr_i == OFS_BASIC_CTRL);
  end

  always_comb
  begin
    next_r = r;
    if (rst_i || (ctl_wr && mgmt_wdata_i[CTL_SOFT_RESET]))
    begin
      next_r = '0;
      next_r.strap_adv = rst_i ? advertise_strap_i : r.strap_adv;
      next_r.strap_iso = rst_i ? addr_zero_strap_i : r.strap_iso;
      next_r.advert = next_r.strap_adv ? ADV_RST_ALL : ADV_RST_HALF;
      next_r.an_en = 1'b1;
      next_r.speed_sel = 1'b1;
      next_r.isolate_bit = next_r.strap_iso;
      next_r.st = AN_NEGOTIATE;
      next_r.isolating = 1'b1;
      next_r.iso_after_rst = 1'b1;
      next_r.iso_cnt = ISO_RST_N;
    end
    else
    begin
      // management reads, clear-on-read flags cleared before any set below
      if (mgmt_rd_i)
      begin
        unique case (mgmt_addr_i)
          OFS_BASIC_CTRL: next_r.rdata = basic_control_rd;
          OFS_BASIC_STAT: next_r.rdata = basic_status_reg_rd;
          OFS_ADVERT:     next_r.rdata = r.advert;
          OFS_PARTNER:    next_r.rdata = r.partner;
          OFS_EXPANSION:  next_r.rdata = negotiation_expansion_reg_rd;
          OFS_PHY_STATUS: next_r.rdata = phy_link_status_rd;
          default:        next_r.rdata = 16'h0000;
        endcase
        if (mgmt_addr_i == OFS_EXPANSION)
        begin
          next_r.page_rx = 1'b0;
          next_r.pd_fault = 1'b0;
        end
      end
      if (mgmt_wr_i && (mgmt_addr_i == OFS_ADVERT))
        next_r.advert = mgmt_wdata_i;

      // negotiation state machine
      unique case (r.st)
        AN_FORCED:
        begin
          next_r.res_100 = r.speed_sel;
          next_r.res_fd = r.duplex_sel;
          next_r.link_up = r.speed_sel ? link_ok_100_i : link_ok_10_i;
        end
        AN_BREAK:
        begin
          next_r.link_up = 1'b0;
          if (r.brk_cnt == 26'h0000000)
            next_r.st = AN_NEGOTIATE;
          else
            next_r.brk_cnt = r.brk_cnt - 26'h0000001;
        end
        AN_NEGOTIATE:
        begin
          if (page_valid_i)
          begin
            next_r.partner = page_word_i;
            next_r.lp_an_able = 1'b1;
            next_r.page_rx = 1'b1;
            next_r.lp_next_page = page_word_i[ADV_NEXT_PAGE];
            if (!page_word_i[ADV_NEXT_PAGE] && (common != 4'h0))
            begin
              next_r.an_complete = 1'b1;
              next_r.st = AN_GOOD;
              next_r.res_100 = common[3] | common[2];
              next_r.res_fd = common[3] | (~common[2] & common[1]);
            end
          end
          else if (!r.lp_an_able && one_link)
          begin
            next_r.partner = link_ok_100_i ? PD_WORD_100 : PD_WORD_10;
            next_r.an_complete = 1'b1;
            next_r.res_100 = link_ok_100_i;
            next_r.res_fd = 1'b0;
            next_r.st = AN_GOOD;
          end
          else if (!r.lp_an_able && link_ok_10_i && link_ok_100_i)
            next_r.pd_fault = 1'b1;
        end
        AN_GOOD:
        begin
          next_r.link_up = res_link_ok;
          if (r.link_up && !res_link_ok)
          begin
            next_r.st = AN_BREAK;
            next_r.brk_cnt = BREAK_LAST;
            next_r.an_complete = 1'b0;
          end
        end
      endcase

      // control register write
      if (ctl_wr)
      begin
        next_r.speed_sel = mgmt_wdata_i[CTL_SPEED_100];
        next_r.duplex_sel = mgmt_wdata_i[CTL_FULL_DUPLEX];
        next_r.isolate_bit = mgmt_wdata_i[CTL_ISOLATE];
        next_r.an_en = mgmt_wdata_i[CTL_AN_ENABLE];
        if (!mgmt_wdata_i[CTL_AN_ENABLE])
        begin
          next_r.st = AN_FORCED;
          next_r.an_complete = 1'b0;
        end
        else if (!r.an_en || mgmt_wdata_i[CTL_RESTART])
        begin
          next_r.st = AN_BREAK;
          next_r.brk_cnt = BREAK_LAST;
          next_r.an_complete = 1'b0;
          next_r.lp_an_able = 1'b0;
          next_r.link_up = 1'b0;
        end
      end

      // isolate exit timing
      if (r.isolate_bit)
      begin
        next_r.isolating = 1'b1;
        next_r.iso_after_rst = 1'b0;
        next_r.iso_cnt = ISO_CLR_N;
      end
      else if (r.isolating)
      begin
        if (r.iso_cnt == 14'h0000)
          next_r.isolating = 1'b0;
        else
          next_r.iso_cnt = r.iso_cnt - 14'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    r <= next_r;
  end

  assign mgmt_rdata_o  = r.rdata;
  assign flp_send_o    = (r.st == AN_NEGOTIATE);
  assign flp_word_o    = r.advert;
  assign tx_halt_o     = (r.st == AN_BREAK);
  assign link_up_o     = r.link_up;
  assign speed_100_o   = r.res_100;
  assign full_duplex_o = r.res_fd;
  assign isolate_o     = r.isolating;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_strap_advert: assert property (
    $fell(rst_i) |-> (r.advert[ADV_100_FD:ADV_10_HD] == ($past(advertise_strap_i) ? 4'hF : 4'h5)))
    else $error("advertised abilities do not follow strap");
  a_break_quiet: assert property (
    (r.st == AN_BREAK) |-> (tx_halt_o && !flp_send_o && !link_up_o))
    else $error("activity during break link");
  a_break_resume: assert property (
    (r.st == AN_BREAK && r.brk_cnt == 26'h0000000 && !ctl_wr) |=> flp_send_o)
    else $error("bursts not resumed after break timer");
  a_pd_word: assert property (
    (r.st == AN_NEGOTIATE && !page_valid_i && !r.lp_an_able && one_link && !ctl_wr)
      |=> (r.partner == ($past(link_ok_100_i) ? PD_WORD_100 : PD_WORD_10)) && r.an_complete
          && !r.lp_an_able)
    else $error("parallel detect result wrong");
  a_pd_fault: assert property (
    (r.st == AN_NEGOTIATE && !page_valid_i && !r.lp_an_able && link_ok_10_i && link_ok_100_i
     && !ctl_wr)
      |=> r.pd_fault)
    else $error("parallel detect fault not raised");
  a_prio_top: assert property (
    (r.st == AN_NEGOTIATE && page_valid_i && !page_word_i[ADV_NEXT_PAGE] && !ctl_wr
     && r.advert[ADV_100_FD] && page_word_i[ADV_100_FD]) |=> (speed_100_o && full_duplex_o))
    else $error("highest common mode not chosen");
  a_forced_mode: assert property (
    (r.st == AN_FORCED && !ctl_wr)
      |=> (speed_100_o == $past(r.speed_sel)) && (full_duplex_o == $past(r.duplex_sel)))
    else $error("forced speed not applied");
  a_restart_go: assert property (
    (ctl_wr && mgmt_wdata_i[CTL_AN_ENABLE] && mgmt_wdata_i[CTL_RESTART]
     && !mgmt_wdata_i[CTL_SOFT_RESET]) |=> (r.st == AN_BREAK) && !r.an_complete)
    else $error("restart not honoured");
  a_link_loss: assert property (
    (r.st == AN_GOOD && r.link_up && !res_link_ok && !ctl_wr) |=> tx_halt_o)
    else $error("link loss did not renegotiate");
  a_iso_bound: assert property (
    (r.isolating && !r.isolate_bit && !r.iso_after_rst) |-> (r.iso_cnt <= ISO_CLR_N))
    else $error("isolate exit longer than allowed");
  a_iso_count: assert property (
    (r.isolating && !r.isolate_bit && r.iso_cnt != 14'h0000 && !ctl_wr && !mgmt_wr_i)
      |=> (r.iso_cnt == $past(r.iso_cnt) - 14'h0001))
    else $error("isolate exit counter stalled");
  a_stat_fixed: assert property (
    (mgmt_rd_i && mgmt_addr_i == OFS_BASIC_STAT && !ctl_wr)
      |=> (mgmt_rdata_o[15:11] == 5'h0F) && mgmt_rdata_o[3] && mgmt_rdata_o[0])
    else $error("status ability bits wrong");

  a_page_capture: assert property (
    (r.st == AN_NEGOTIATE && page_valid_i && !ctl_wr)
      |=> (r.partner == $past(page_word_i)) && r.lp_an_able && r.page_rx)
    else $error("partner page not captured");
  a_pd_select: assert property (
    (r.st == AN_NEGOTIATE && !page_valid_i && !r.lp_an_able && one_link && !ctl_wr)
      |=> (r.partner[4:0] == SELECTOR_8023))
    else $error("parallel detect selector wrong");
  a_prio_second: assert property (
    (r.st == AN_NEGOTIATE && page_valid_i && !page_word_i[ADV_NEXT_PAGE] && !ctl_wr
     && !common[3] && common[2]) |=> (speed_100_o && !full_duplex_o))
    else $error("100 half duplex not chosen");
  a_prio_third: assert property (
    (r.st == AN_NEGOTIATE && page_valid_i && !page_word_i[ADV_NEXT_PAGE] && !ctl_wr
     && !common[3] && !common[2] && common[1]) |=> (!speed_100_o && full_duplex_o))
    else $error("10 full duplex not chosen");
  a_prio_last: assert property (
    (r.st == AN_NEGOTIATE && page_valid_i && !page_word_i[ADV_NEXT_PAGE] && !ctl_wr
     && (common == 4'h1)) |=> (!speed_100_o && !full_duplex_o))
    else $error("10 half duplex not chosen");

  a_ctl_ignored: assert property (
    (r.st == AN_GOOD && r.an_en && ctl_wr && mgmt_wdata_i[CTL_AN_ENABLE]
     && !mgmt_wdata_i[CTL_RESTART] && !mgmt_wdata_i[CTL_SOFT_RESET])
      |=> $stable(speed_100_o) && $stable(full_duplex_o))
    else $error("speed or duplex bits changed negotiated mode");
  a_an_off: assert property (
    (ctl_wr && !mgmt_wdata_i[CTL_AN_ENABLE] && !mgmt_wdata_i[CTL_SOFT_RESET])
      |=> (r.st == AN_FORCED) && !flp_send_o && !tx_halt_o)
    else $error("forced mode not entered");
  a_phy_status: assert property (
    (mgmt_rd_i && mgmt_addr_i == OFS_PHY_STATUS && !ctl_wr)
      |=> (mgmt_rdata_o[2:0] == {$past(full_duplex_o), ~$past(speed_100_o), $past(link_up_o)}))
    else $error("phy status contents wrong");
  a_stat_live: assert property (
    (mgmt_rd_i && mgmt_addr_i == OFS_BASIC_STAT && !ctl_wr)
      |=> (mgmt_rdata_o[5] == $past(r.an_complete)) && (mgmt_rdata_o[2] == $past(link_up_o)))
    else $error("status completion or link wrong");
  a_link_follow: assert property (
    (r.st == AN_GOOD && !ctl_wr) |=> (link_up_o == $past(res_link_ok)))
    else $error("link indication does not follow receiver");
  a_expand_fixed: assert property (
    (mgmt_rd_i && mgmt_addr_i == OFS_EXPANSION && !ctl_wr)
      |=> mgmt_rdata_o[2] && (mgmt_rdata_o[15:5] == 11'h000))
    else $error("expansion register contents wrong");
  a_adv_write: assert property (
    (mgmt_wr_i && mgmt_addr_i == OFS_ADVERT) |=> (flp_word_o == $past(mgmt_wdata_i)))
    else $error("advertisement write not sent");

  a_break_len: assert property (
    (r.st == AN_BREAK && r.brk_cnt != 26'h0000000 && !ctl_wr)
      |=> (r.st == AN_BREAK) && (r.brk_cnt == $past(r.brk_cnt) - 26'h0000001))
    else $error("break timer cut short");
  a_iso_enter: assert property (
    r.isolate_bit |=> isolate_o)
    else $error("isolate bit did not isolate");
  a_iso_exit: assert property (
    (r.isolating && !r.isolate_bit && r.iso_cnt == 14'h0000 && !ctl_wr) |=> !isolate_o)
    else $error("isolate mode not left");
  a_reset_state: assert property (
    $fell(rst_i) |-> (isolate_o && flp_send_o && !link_up_o))
    else $error("state after reset wrong");
  a_soft_reset: assert property (
    (ctl_wr && mgmt_wdata_i[CTL_SOFT_RESET]) |=> isolate_o && (r.iso_cnt == ISO_RST_N))
    else $error("soft reset did not restart isolate timing");

endmodule // an_autoneg_ctrl

`default_nettype wire

/* File: verilog/an_pkg.sv */
// constants, register map and state encoding of the negotiation control block
// assumes a single 25 MHz system clock
package an_pkg;

  localparam int          CLK_HZ          = 25_000_000;
  localparam int          CLK_PER_US      = CLK_HZ / 1_000_000;
  localparam int          BREAK_MS        = 1500;
  localparam int          BREAK_CYC       = BREAK_MS * (CLK_HZ / 1000);
  localparam int          ISO_CLR_US      = 100;
  localparam int          ISO_CLR_CYC     = ISO_CLR_US * CLK_PER_US;
  localparam int          ISO_RST_US      = 500;
  localparam int          ISO_RST_CYC     = ISO_RST_US * CLK_PER_US;

  localparam logic [4:0]  OFS_BASIC_CTRL  = 5'h00;
  localparam logic [4:0]  OFS_BASIC_STAT  = 5'h01;
  localparam logic [4:0]  OFS_ADVERT      = 5'h04;
  localparam logic [4:0]  OFS_PARTNER     = 5'h05;
  localparam logic [4:0]  OFS_EXPANSION   = 5'h06;
  localparam logic [4:0]  OFS_PHY_STATUS  = 5'h10;

  localparam int          CTL_SOFT_RESET  = 15;
  localparam int          CTL_SPEED_100   = 13;
  localparam int          CTL_AN_ENABLE   = 12;
  localparam int          CTL_ISOLATE     = 10;
  localparam int          CTL_RESTART     = 9;
  localparam int          CTL_FULL_DUPLEX = 8;

  localparam int          ADV_100_FD      = 8;
  localparam int          ADV_100_HD      = 7;
  localparam int          ADV_10_FD       = 6;
  localparam int          ADV_10_HD       = 5;
  localparam int          ADV_REMOTE_FLT  = 13;
  localparam int          ADV_NEXT_PAGE   = 15;

  localparam logic [15:0] ADV_RST_HALF    = 16'h00A1;
  localparam logic [15:0] ADV_RST_ALL     = 16'h01E1;
  localparam logic [15:0] PD_WORD_100     = 16'h0081;
  localparam logic [15:0] PD_WORD_10      = 16'h0021;
  localparam logic [4:0]  SELECTOR_8023   = 5'h01;
  localparam logic [15:0] STAT_FIXED      = 16'h7849;

  typedef enum logic [1:0] {
    AN_FORCED,
    AN_BREAK,
    AN_NEGOTIATE,
    AN_GOOD
  } an_state_t;

endpackage
